// ---- design/gdl_channel.sv ----
/*
 * Graphics display-list channel: fetches words from memory through the
 * block arbiter, forwards data and instruction words to the display
 * system, and executes branch, store-return-and-branch and stop.
 * Assumes an APB master on core_clk, an arbiter answering with a one-cycle
 * memory-available pulse carrying read data, and display request pins
 * from outside the clock domain.
 */
// Added by the designer: the APB interface to the registers and the placing of the registers.
`include "gdl_regs.svh"
`timescale 1ns/10ps
`default_nettype none

module gdl_channel
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Block priority arbiter side
    output gdl_pkg::gdl_mem_req_t mem_req,
    output logic [2:0] priority_slot,
    input wire logic mem_available,
    input wire logic [15:0] mem_rdata,
    // Display system side
    input wire logic disp_data_req,
    input wire logic disp_addr_req,
    output gdl_pkg::gdl_disp_t disp_out,
    output logic block_stopped
);
    import gdl_pkg::*;

    typedef enum logic [2:0] {GDL_IDLE, GDL_FETCH, GDL_ADDR, GDL_STORE, GDL_STOPPED} gdl_state_t;

    gdl_state_t state;
    logic [14:0] current_word_address;
    logic [14:0] return_register;
    logic [1:0] ctrl;
    logic [2:0] slot;
    logic is_spb;
    logic addr_first;
    logic in_instr;
    logic start_pend;
    logic [14:0] start_addr;
    logic data_req_s1, data_req_s2, addr_req_s1, addr_req_s2;
    logic apb_wr, apb_rd;
    logic [15:0] w;
    logic is_instr;
    logic [2:0] cmd;

    assign apb_wr = psel && penable && pwrite;
    assign apb_rd = psel && !penable && !pwrite;
    assign w = mem_rdata;
    assign is_instr = (w[15:12] == `GDL_INSTR_CODE);
    assign cmd = w[2:0];

    // Pin synchronisers
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            data_req_s1 <= 1'b0;
            data_req_s2 <= 1'b0;
            addr_req_s1 <= 1'b0;
            addr_req_s2 <= 1'b0;
        end
        else
        begin
            data_req_s1 <= disp_data_req;
            data_req_s2 <= data_req_s1;
            addr_req_s1 <= disp_addr_req;
            addr_req_s2 <= addr_req_s1;
        end
    end

    // APB register writes; a start arms one address-load cycle
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            ctrl <= 2'b00;
            slot <= `GDL_SLOT_RESET;
            start_pend <= 1'b0;
            start_addr <= 15'h0000;
        end
        else
        begin
            if (apb_wr && paddr == `GDL_OFF_CTRL)
            begin
                ctrl <= pwdata[1:0];
            end
            if (apb_wr && paddr == `GDL_OFF_SLOT)
            begin
                // Graphics-only systems start at slot three; slot one and two reserved for block channels
                if (ctrl[`GDL_CTRL_GFX_ONLY] && pwdata[2:0] < `GDL_GFX_TOP_SLOT)
                begin
                    slot <= `GDL_GFX_TOP_SLOT;
                end
                else
                begin
                    slot <= pwdata[2:0];
                end
            end
            if (apb_wr && paddr == `GDL_OFF_START)
            begin
                start_pend <= 1'b1;
                start_addr <= pwdata[14:0];
            end
            else if (start_pend && (state == GDL_IDLE || state == GDL_STOPPED) && addr_req_s2)
            begin
                start_pend <= 1'b0;
            end
        end
    end

    // Channel sequencer
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            state <= GDL_IDLE;
            current_word_address <= 15'h0000;
            return_register <= 15'h0000;
            is_spb <= 1'b0;
            addr_first <= 1'b0;
            in_instr <= 1'b0;
            mem_req <= '0;
            disp_out <= '0;
            block_stopped <= 1'b0;
        end
        else
        begin
            disp_out.valid <= 1'b0;
            case (state)
                GDL_IDLE, GDL_STOPPED:
                begin
                    // Only the address-transfer request is honoured here
                    // Single load of the word address, no word count
                    if (start_pend && addr_req_s2 && ctrl[`GDL_CTRL_ENABLE])
                    begin
                        current_word_address <= start_addr;
                        block_stopped <= 1'b0;
                        state <= GDL_FETCH;
                    end
                end
                GDL_FETCH:
                begin
                    // Read-only fetch; fast-unit single word per request
                    if (!mem_req.req && data_req_s2)
                    begin
                        mem_req.req <= 1'b1;
                        mem_req.write <= 1'b0;
                        mem_req.addr <= current_word_address;
                    end
                    else if (mem_req.req && mem_available)
                    begin
                        mem_req.req <= 1'b0;
                        current_word_address <= current_word_address + 15'h0001;
                        disp_out.valid <= 1'b1;
                        disp_out.data <= w;
                        if (is_instr && cmd == `GDL_CMD_STOP)
                        begin
                            block_stopped <= 1'b1;
                            state <= GDL_STOPPED;
                        end
                        else if (is_instr && (cmd == `GDL_CMD_BRU || cmd == `GDL_CMD_SPB))
                        begin
                            is_spb <= (cmd == `GDL_CMD_SPB);
                            // Only the first address fetch of a call saves the return point
                            addr_first <= 1'b1;
                            in_instr <= 1'b1;
                            state <= GDL_ADDR;
                        end
                    end
                end
                GDL_ADDR:
                begin
                    if (!mem_req.req)
                    begin
                        mem_req.req <= 1'b1;
                        mem_req.write <= 1'b0;
                        mem_req.addr <= current_word_address;
                    end
                    else if (mem_available)
                    begin
                        mem_req.req <= 1'b0;
                        addr_first <= 1'b0;
                        if (is_spb && addr_first)
                        begin
                            return_register <= current_word_address + 15'h0001;
                        end
                        // Address word not shown to the display
                        current_word_address <= {w[15], w[13:0]};
                        if (!w[14])
                        begin
                            state <= is_spb ? GDL_STORE : GDL_FETCH;
                            in_instr <= is_spb;
                        end
                        // Indirect flag set: fetch again at the new address
                    end
                end
                GDL_STORE:
                begin
                    if (!mem_req.req)
                    begin
                        mem_req.req <= 1'b1;
                        mem_req.write <= 1'b1;
                        mem_req.addr <= current_word_address;
                        // Return word in address-word layout, indirect flag clear
                        mem_req.wdata <= {return_register[14], 1'b0, return_register[13:0]};
                    end
                    else if (mem_available)
                    begin
                        mem_req.req <= 1'b0;
                        mem_req.write <= 1'b0;
                        current_word_address <= current_word_address + 15'h0001;
                        in_instr <= 1'b0;
                        state <= GDL_FETCH;
                    end
                end
                default:
                begin
                    state <= GDL_IDLE;
                end
            endcase
        end
    end

    // APB read data and handshake
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            priority_slot <= `GDL_SLOT_RESET;
        end
        else
        begin
            priority_slot <= slot;
            pready <= psel && !penable;
            pslverr <= psel && !penable && paddr != `GDL_OFF_CTRL && paddr != `GDL_OFF_STATUS
                && paddr != `GDL_OFF_START && paddr != `GDL_OFF_CWA && paddr != `GDL_OFF_RET
                && paddr != `GDL_OFF_SLOT;
            if (apb_rd)
            begin
                case (paddr)
                    `GDL_OFF_CTRL: prdata <= {30'h0, ctrl};
                    `GDL_OFF_STATUS: prdata <= {29'h0, in_instr, block_stopped, state != GDL_IDLE && state != GDL_STOPPED};
                    `GDL_OFF_START: prdata <= {17'h0, start_addr};
                    `GDL_OFF_CWA: prdata <= {17'h0, current_word_address};
                    `GDL_OFF_RET: prdata <= {17'h0, return_register};
                    `GDL_OFF_SLOT: prdata <= {29'h0, slot};
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    AST_STOP_HALTS: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state == GDL_FETCH && mem_req.req && mem_available && is_instr && cmd == `GDL_CMD_STOP)
        |=> state == GDL_STOPPED && block_stopped) else $error("stop did not halt");
    AST_STOPPED_NO_REQ: assert property (@(posedge core_clk) disable iff (!rst_n)
        state == GDL_STOPPED |-> !mem_req.req) else $error("memory request while stopped");
    AST_NO_WRITE_OUTSIDE_STORE: assert property (@(posedge core_clk) disable iff (!rst_n)
        mem_req.write |-> state == GDL_STORE) else $error("write outside store cycle");
    AST_ADDR_NOT_SHOWN: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state == GDL_ADDR && mem_req.req && mem_available) |=> !disp_out.valid)
        else $error("address word forwarded");
    AST_BRANCH_LOAD: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state == GDL_ADDR && mem_req.req && mem_available)
        |=> current_word_address == {$past(mem_rdata[15]), $past(mem_rdata[13:0])})
        else $error("branch target not loaded");
    AST_STORE_WORD: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state == GDL_STORE && mem_req.req)
        |-> {mem_req.wdata[15], mem_req.wdata[13:0]} == return_register && !mem_req.wdata[14])
        else $error("wrong return word");
    AST_INDIRECT_LOOP: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state == GDL_ADDR && mem_req.req && mem_available && mem_rdata[14]) |=> state == GDL_ADDR)
        else $error("indirect chain left");
    AST_INSTR_BUSY: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state == GDL_ADDR || state == GDL_STORE) |-> in_instr) else $error("instruction flag low");

    // Plain data words go out unchanged and the fetch goes on
    AST_DATA_FORWARD: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state == GDL_FETCH && mem_req.req && mem_available && !is_instr)
        |=> disp_out.valid && disp_out.data == $past(mem_rdata) && state == GDL_FETCH)
        else $error("data word not forwarded");
    // Stop word is forwarded as well
    AST_STOP_FORWARD: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state == GDL_FETCH && mem_req.req && mem_available && is_instr && cmd == `GDL_CMD_STOP)
        |=> disp_out.valid && disp_out.data == $past(mem_rdata))
        else $error("stop word not forwarded");
    // Branch decodes to an address fetch
    AST_BRU_DECODE: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state == GDL_FETCH && mem_req.req && mem_available && is_instr && cmd == `GDL_CMD_BRU)
        |=> state == GDL_ADDR && !is_spb && in_instr && disp_out.valid)
        else $error("branch not decoded");
    // Call decodes to an address fetch with return save
    AST_SPB_DECODE: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state == GDL_FETCH && mem_req.req && mem_available && is_instr && cmd == `GDL_CMD_SPB)
        |=> state == GDL_ADDR && is_spb && in_instr && disp_out.valid)
        else $error("call not decoded");
    // Each data fetch advances the word address by one
    AST_FETCH_INCR: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state == GDL_FETCH && mem_req.req && mem_available)
        |=> current_word_address == $past(current_word_address) + 15'h0001)
        else $error("word address not advanced");
    // Start loads only the word address
    AST_START_LOAD: assert property (@(posedge core_clk) disable iff (!rst_n)
        ((state == GDL_IDLE || state == GDL_STOPPED) && start_pend && addr_req_s2 && ctrl[`GDL_CTRL_ENABLE])
        |=> state == GDL_FETCH && current_word_address == $past(start_addr))
        else $error("start not loaded");
    // A stopped channel stays stopped until a new start
    AST_NO_AUTO_RESTART: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state == GDL_STOPPED && !start_pend) |=> state == GDL_STOPPED)
        else $error("channel restarted itself");
    // Nothing reaches the display after stop
    AST_STOPPED_QUIET: assert property (@(posedge core_clk) disable iff (!rst_n)
        state == GDL_STOPPED |=> !disp_out.valid)
        else $error("display word after stop");
    // No display traffic while an instruction runs
    AST_INSTR_QUIET: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state == GDL_ADDR || state == GDL_STORE) |=> !disp_out.valid)
        else $error("display word during instruction");
    // Fetches never write memory
    AST_READ_ONLY_FETCH: assert property (@(posedge core_clk) disable iff (!rst_n)
        ((state == GDL_FETCH || state == GDL_ADDR) && mem_req.req) |-> !mem_req.write)
        else $error("write during fetch");
    // Return point is the word after the address word
    AST_SPB_RETURN: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state == GDL_ADDR && mem_req.req && mem_available && is_spb && addr_first)
        |=> return_register == $past(current_word_address) + 15'h0001)
        else $error("return point not saved");
    // Direct branch target hands control back to the display
    AST_BRU_EXIT: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state == GDL_ADDR && mem_req.req && mem_available && !is_spb && !mem_rdata[14])
        |=> state == GDL_FETCH && !in_instr)
        else $error("branch did not return control");
    // Direct call target goes on to the store cycle
    AST_SPB_EXIT: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state == GDL_ADDR && mem_req.req && mem_available && is_spb && !mem_rdata[14])
        |=> state == GDL_STORE)
        else $error("call skipped store");
    // Store goes to the loaded target address
    AST_STORE_ADDR: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state == GDL_STORE && mem_req.req) |-> mem_req.addr == current_word_address && mem_req.write)
        else $error("store at wrong address");
    // Store completion advances the address and resumes fetching
    AST_STORE_INCR: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state == GDL_STORE && mem_req.req && mem_available)
        |=> current_word_address == $past(current_word_address) + 15'h0001 && state == GDL_FETCH)
        else $error("store did not advance");
    // A request stands unchanged until memory is available
    AST_REQ_HOLD: assert property (@(posedge core_clk) disable iff (!rst_n)
        (mem_req.req && !mem_available) |=> mem_req.req && mem_req.addr == $past(mem_req.addr))
        else $error("memory request dropped");
    // Graphics-only systems never go below slot three
    AST_SLOT_CLAMP: assert property (@(posedge core_clk) disable iff (!rst_n)
        (apb_wr && paddr == `GDL_OFF_SLOT && ctrl[`GDL_CTRL_GFX_ONLY] && pwdata[2:0] < `GDL_GFX_TOP_SLOT)
        |=> slot == `GDL_GFX_TOP_SLOT)
        else $error("slot not clamped");
    // Slot output follows the slot register
    AST_SLOT_PORT: assert property (@(posedge core_clk) disable iff (!rst_n)
        1'b1 |=> priority_slot == $past(slot))
        else $error("slot output stale");
endmodule

`default_nettype wire

// ---- design/gdl_regs.svh ----
/*
 * Register offsets, field positions, reset values and encodings of the
 * graphics display-list channel. Assumes inclusion from gdl_pkg.sv and from the channel module.
 */
`ifndef GDL_REGS_SVH
`define GDL_REGS_SVH

`define GDL_OFF_CTRL 8'h00
`define GDL_OFF_STATUS 8'h04
`define GDL_OFF_START 8'h08
`define GDL_OFF_CWA 8'h0C
`define GDL_OFF_RET 8'h10
`define GDL_OFF_SLOT 8'h14

`define GDL_CTRL_ENABLE 0
`define GDL_CTRL_GFX_ONLY 1
`define GDL_STATUS_BUSY 0
`define GDL_STATUS_STOPPED 1
`define GDL_STATUS_INSTR 2

`define GDL_INSTR_CODE 4'h3
`define GDL_CMD_BRU 3'h1
`define GDL_CMD_SPB 3'h2
`define GDL_CMD_STOP 3'h4

`define GDL_SLOT_RESET 3'h7
`define GDL_SLOT_MAX 3'h7
`define GDL_GFX_TOP_SLOT 3'h2
`define GDL_GFX_MAX_CHANNELS 4'h6
`define GDL_ADDR_W 15

`endif

// ---- design/gdl_pkg.sv ----
/*
 * Types of the graphics display-list channel.
 * Assumes gdl_regs.svh lies beside this file.
 */
`include "gdl_regs.svh"

package gdl_pkg;
    typedef struct packed {
        logic req;
        logic write;
        logic [14:0] addr;
        logic [15:0] wdata;
    } gdl_mem_req_t;

    typedef struct packed {
        logic valid;
        logic [15:0] data;
    } gdl_disp_t;
endpackage

// ---- verification/gdl_far_model.sv ----
/*
 * Far-side model: block arbiter with a small memory, and the display
 * system that requests words and captures what the channel sends.
 * Assumes one gdl_channel on the same core_clk; memory is loaded by the bench.
 */
`timescale 1ns/10ps
`default_nettype none

module gdl_far_model
(
    // Clock
    input wire logic core_clk,
    // Arbiter side
    input wire gdl_pkg::gdl_mem_req_t mem_req,
    output logic mem_available,
    output logic [15:0] mem_rdata,
    // Display side
    input wire gdl_pkg::gdl_disp_t disp_out,
    output logic disp_data_req,
    output logic stop_irq
);
    import gdl_pkg::*;
    logic [15:0] mem [0:127];
    logic [15:0] seen [$];
    int dly = 0;
    int grants = 0;
    int writes = 0;
    initial
    begin
        mem_available = 1'b0;
        mem_rdata = 16'h0000;
        disp_data_req = 1'b1;
        stop_irq = 1'b0;
    end
    // One access at a time, granted after a wait of 0 to 2 cycles
    always @(posedge core_clk)
    begin
        mem_rdata <= ~mem_rdata;
        if (mem_available)
            mem_available <= 1'b0;
        else if (mem_req.req)
        begin
            if (dly == 0)
            begin
                mem_available <= 1'b1;
                mem_rdata <= mem[mem_req.addr[6:0]];
                if (mem_req.write)
                begin
                    mem[mem_req.addr[6:0]] <= mem_req.wdata;
                    writes <= writes + 1;
                end
                grants <= grants + 1;
                dly <= grants % 3;
            end
            else
                dly <= dly - 1;
        end
    end
    // Capture words; a forwarded stop raises the interrupt request
    always @(posedge core_clk)
        if (disp_out.valid === 1'b1)
        begin
            seen.push_back(disp_out.data);
            if (disp_out.data[15:12] == 4'h3 && disp_out.data[2:0] == 3'h4)
                stop_irq <= 1'b1;
        end
endmodule

`default_nettype wire

// ---- verification/graphics_display_list_dma_test.sv ----
/*
 * Self-checking bench of the graphics display-list channel.
 * Assumes gdl_pkg, gdl_channel and gdl_far_model compiled before it.
 */
`timescale 1ns/10ps
`default_nettype none

module graphics_display_list_dma_test;
    import gdl_pkg::*;
    logic core_clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    gdl_mem_req_t mem_req;
    gdl_disp_t disp_out;
    logic [2:0] priority_slot;
    logic mem_available, disp_data_req, disp_addr_req, block_stopped, stop_irq;
    logic [15:0] mem_rdata;
    logic [15:0] exp_w [8] = '{16'h1234, 16'hA5A5, 16'h3001, 16'h2FFF, 16'h3002, 16'h0000, 16'h3001, 16'h3004};
    int error_cnt = 0;
    int cmp_count = 0;

    gdl_channel DUT (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .mem_req(mem_req), .priority_slot(priority_slot), .mem_available(mem_available),
        .mem_rdata(mem_rdata), .disp_data_req(disp_data_req), .disp_addr_req(disp_addr_req),
        .disp_out(disp_out), .block_stopped(block_stopped));
    gdl_far_model FAR (.core_clk(core_clk), .mem_req(mem_req), .mem_available(mem_available),
        .mem_rdata(mem_rdata), .disp_out(disp_out), .disp_data_req(disp_data_req), .stop_irq(stop_irq));

    initial
    begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic stop_test;
        if (error_cnt == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n = 0;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge core_clk);
        penable <= 1'b1;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (n >= 50)
            error_cnt++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Load the start address, then raise the address-transfer request
    task automatic start_at(input logic [14:0] a);
        int n = 0;
        apb(1'b1, 8'h08, {17'h0, a});
        disp_addr_req <= 1'b1;
        repeat (4) @(posedge core_clk);
        disp_addr_req <= 1'b0;
        while (block_stopped !== 1'b1 && n < 2000)
        begin
            @(posedge core_clk);
            n++;
        end
        if (n >= 2000)
            error_cnt++;
        repeat (2) @(posedge core_clk);
    endtask

    initial
    begin
        #60000;
        error_cnt++;
        stop_test;
    end

    initial
    begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        disp_addr_req = 1'b0;
        // List: data, branch, call through an indirect word, return by indirect branch, stop
        FAR.mem['h10] = 16'h1234;
        FAR.mem['h11] = 16'hA5A5;
        FAR.mem['h12] = 16'h3001;
        FAR.mem['h13] = 16'h0020;
        FAR.mem['h20] = 16'h2FFF;
        FAR.mem['h21] = 16'h3002;
        FAR.mem['h22] = 16'h4030;
        FAR.mem['h30] = 16'h0040;
        FAR.mem['h40] = 16'hFFFF;
        FAR.mem['h41] = 16'h0000;
        FAR.mem['h42] = 16'h3001;
        FAR.mem['h43] = 16'h4040;
        FAR.mem['h23] = 16'h3004;
        FAR.mem['h50] = 16'h3004;
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        apb(1'b0, 8'h14, 32'h0);
        chk("slot_reset", rd, 32'h7);
        apb(1'b0, 8'h04, 32'h0);
        chk("status_reset", rd, 32'h0);
        apb(1'b0, 8'h18, 32'h0);
        chk("unmapped_err", err, 32'h1);
        apb(1'b1, 8'h00, 32'h3);
        apb(1'b1, 8'h14, 32'h0);
        apb(1'b0, 8'h14, 32'h0);
        chk("slot_clamp", rd, 32'h2);
        chk("slot_port", priority_slot, 32'h2);
        start_at(15'h0010);
        chk("stopped", block_stopped, 32'h1);
        repeat (40) @(posedge core_clk);
        chk("word_count", FAR.seen.size(), 32'd8);
        foreach (exp_w[i]) chk("word", FAR.seen[i], exp_w[i]);
        chk("ret_store", FAR.mem['h40], 32'h0023);
        chk("mem_writes", FAR.writes, 32'd1);
        chk("stop_irq", stop_irq, 32'h1);
        apb(1'b0, 8'h10, 32'h0);
        chk("ret_reg", rd, 32'h0023);
        apb(1'b0, 8'h04, 32'h0);
        chk("status_stopped", rd[1], 32'h1);
        start_at(15'h0050);
        chk("restart_count", FAR.seen.size(), 32'd9);
        chk("restart_word", FAR.seen[8], 32'h3004);
        stop_test;
    end
endmodule

`default_nettype wire
